// ---- logic/scs_sequencer.sv ----
// How it works
// - Resolution bit picks 10-bit quad or 12-bit single
// - 12-bit mode never samples channels together
// - Module-on bit 15 runs or stops converter
// - Idle-stop bit halts sequencer during idle mode
// - Build mode set: in-order stand-alone buffer address
// - Build mode clear: scatter/gather address from input
// - DMA request whenever the interrupt flag sets
// - Increment-rate field sets DMA pointer advance rate
// - Four result formats for 10-bit data
// - Same four formats for 12-bit data
// - Trigger field chooses what ends sampling
// - Timer codes swap timers between module instances
// - Simultaneous bit samples selected channels together
// - Simultaneous bit reads zero in 12-bit mode
// - Auto-start resamples right after a sequence ends
// - With software trigger, sample bit cleared ends sampling, starts conversion
// - Done sets at completion, clears at next start
// - Bits 14, 11, 4 ignore writes, read zero
// - Flag and pointer every N+1 conversions
// - Channel count selects one, two or four
// - Sample time counts 0 to 31 conversion clocks
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
	parameter int MODULE_IDX = 0
) (
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	// Register port
	input  wire logic [scs_pkg::REG_AW-1:0]       reg_addr,
	input  wire logic [scs_pkg::DW-1:0]           reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [scs_pkg::DW-1:0]           reg_rdata,
	// Device state and trigger sources
	input  wire logic                             idle_mode,
	input  wire logic                             external_interrupt_pin,
	input  wire logic                             general_timer_b_match,
	input  wire logic                             general_timer_c_match,
	// Converter core
	output logic      [3:0]                       sh_sampling,
	output logic                                  conv_start,
	output logic      [1:0]                       conv_channel,
	output logic                                  conv_res12,
	input  wire logic                             conv_done,
	input  wire logic [scs_pkg::RAW_W-1:0]        conv_data,
	input  wire logic [4:0]                       conv_input_idx,
	// DMA channel and interrupt
	output logic                                  dma_req,
	output logic      [scs_pkg::DW-1:0]           dma_addr,
	output logic      [scs_pkg::DW-1:0]           dma_data,
	output logic                                  irq_set
);
	import scs_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic          on_r, idle_stop_r, build_r, res12_r, simul_r, auto_r;
	logic          sample_r, done_r, pin_d_r, start_r, dreq_r;
	logic [1:0]    fmt_r, chcnt_r, ch_r;
	logic [2:0]    trig_r, blog_r;
	logic [3:0]    incr_r, ops_r;
	logic [4:0]    smpt_r, smp_cnt_r;
	logic [7:0]    div_r, tad_cnt_r;
	logic [6:0]    ptr_r, ptr_mask;
	logic [DW-1:0] result_r, rdata_r, daddr_r, ddata_r;
	scs_state_t    state_r;
	logic          wr_c1, run, simul_eff, tad_tick, pin_rise, tmr_lo, tmr_hi;
	logic          swr_start, swr_end, end_smp, go_sample, go_conv, res_take;
	logic          seq_end, group_end;
	logic [1:0]    last_ch;
	logic [3:0]    active;

	scs_link_if lnk ();

	// ------------------------------------------------------------
	// Helpers shared by the processes
	// ------------------------------------------------------------
	assign wr_c1     = reg_wr && (reg_addr == OFS_CTRL1);
	assign run       = on_r && !(idle_stop_r && idle_mode);
	assign simul_eff = simul_r && !res12_r;
	// 12-bit mode has only the one sample/hold
	assign last_ch   = res12_r ? 2'd0 : (chcnt_r[1] ? 2'd3 : {1'b0, chcnt_r[0]});
	assign active    = {last_ch == 2'd3, last_ch == 2'd3, last_ch != 2'd0, 1'b1};
	assign tad_tick  = (tad_cnt_r == div_r);
	assign pin_rise  = external_interrupt_pin && !pin_d_r;
	// Timer pairing is mirrored on the second instance
	assign tmr_hi    = (MODULE_IDX == 0) ? general_timer_c_match : general_timer_b_match;
	assign tmr_lo    = (MODULE_IDX == 0) ? general_timer_b_match : general_timer_c_match;
	assign swr_start = wr_c1 && reg_wdata[B_SAMPLE] && !auto_r;
	assign swr_end   = wr_c1 && !reg_wdata[B_SAMPLE];
	assign ptr_mask  = 7'((8'h01 << blog_r) - 8'h01);

	always_comb begin
		unique case (trig_r)
			TRIG_AUTO:   end_smp = (smp_cnt_r == smpt_r);
			TRIG_PIN:    end_smp = pin_rise;
			TRIG_TMR_HI: end_smp = tmr_hi;
			TRIG_TMR_LO: end_smp = tmr_lo;
			TRIG_SW:     end_smp = swr_end;
			// Reserved codes never end sampling
			default:     end_smp = 1'b0;
		endcase
	end

	assign go_sample = run && (((state_r == SCS_OFF) && auto_r)
	                 || ((state_r == SCS_WAIT) && (auto_r || swr_start))
	                 || (seq_end && auto_r));
	assign go_conv   = run && (state_r == SCS_SAMPLE) && end_smp;
	assign res_take  = run && (state_r == SCS_CONV) && conv_done;
	assign seq_end   = res_take && (ch_r == last_ch);
	assign group_end = res_take && (ops_r == incr_r);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			on_r        <= CTRL_RST[B_ON];
			idle_stop_r <= CTRL_RST[B_IDLE];
			build_r     <= CTRL_RST[B_BUILD];
			res12_r     <= CTRL_RST[B_RES12];
			fmt_r       <= CTRL_RST[B_FMT +: 2];
			trig_r      <= CTRL_RST[B_TRIG +: 3];
			simul_r     <= CTRL_RST[B_SIMUL];
			auto_r      <= CTRL_RST[B_AUTO];
			chcnt_r     <= CTRL_RST[B_CHCNT +: 2];
			incr_r      <= CTRL_RST[B_INCR +: 4];
			smpt_r      <= CTRL_RST[B_SMPT +: 5];
			div_r       <= CTRL_RST[B_DIV +: 8];
			blog_r      <= CTRL_RST[B_BLOG +: 3];
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_CTRL1: begin
					on_r        <= reg_wdata[B_ON];
					idle_stop_r <= reg_wdata[B_IDLE];
					build_r     <= reg_wdata[B_BUILD];
					// Not guarded: a change while running corrupts the pass
					res12_r     <= reg_wdata[B_RES12];
					fmt_r       <= reg_wdata[B_FMT +: 2];
					trig_r      <= reg_wdata[B_TRIG +: 3];
					simul_r     <= reg_wdata[B_SIMUL];
					auto_r      <= reg_wdata[B_AUTO];
				end
				OFS_CTRL2: begin
					chcnt_r <= reg_wdata[B_CHCNT +: 2];
					incr_r  <= reg_wdata[B_INCR +: 4];
				end
				OFS_CTRL3: begin
					smpt_r <= reg_wdata[B_SMPT +: 5];
					div_r  <= reg_wdata[B_DIV +: 8];
				end
				OFS_CTRL4: blog_r <= reg_wdata[B_BLOG +: 3];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b || !on_r) begin
			state_r <= SCS_OFF;
			ch_r    <= 2'd0;
		end else if (run) begin
			unique case (state_r)
				SCS_OFF:    state_r <= auto_r ? SCS_SAMPLE : SCS_WAIT;
				SCS_WAIT:   if (go_sample) state_r <= SCS_SAMPLE;
				SCS_SAMPLE: if (go_conv) begin
					state_r <= SCS_CONV;
					ch_r    <= 2'd0;
				end
				SCS_CONV:   if (seq_end) begin
					state_r <= auto_r ? SCS_SAMPLE : SCS_WAIT;
				end else if (res_take) begin
					ch_r <= ch_r + 2'd1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !on_r) begin
			sample_r <= 1'b0;
			start_r  <= 1'b0;
		end else begin
			if (go_sample) sample_r <= 1'b1;
			else if (go_conv) sample_r <= 1'b0;
			start_r <= go_conv || (res_take && !seq_end);
		end
	end

	// Sample timer in conversion clock periods
	always_ff @(posedge clk) begin
		if (!rst_b || (state_r != SCS_SAMPLE)) begin
			tad_cnt_r <= 8'h00;
			smp_cnt_r <= 5'h00;
		end else if (run) begin
			tad_cnt_r <= tad_tick ? 8'h00 : tad_cnt_r + 8'h01;
			if (tad_tick && (smp_cnt_r != smpt_r)) smp_cnt_r <= smp_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) pin_d_r <= 1'b0;
		else pin_d_r <= external_interrupt_pin;
	end

	// Set wins over both clears
	always_ff @(posedge clk) begin
		if (!rst_b) done_r <= 1'b0;
		else if (seq_end) done_r <= 1'b1;
		else if (go_conv) done_r <= 1'b0;
		else if (wr_c1 && !reg_wdata[B_DONE]) done_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Results, DMA and flag
	// ------------------------------------------------------------
	assign lnk.raw    = conv_data;
	assign lnk.res12  = res12_r;
	assign lnk.fmt    = fmt_r;
	assign lnk.build  = build_r;
	assign lnk.blog   = blog_r;
	assign lnk.ain    = conv_input_idx;
	assign lnk.op_idx = ops_r;
	assign lnk.ptr    = ptr_r;

	scs_fmt u_fmt (
		.lnk (lnk)
	);
	scs_dma_addr u_addr (
		.lnk (lnk)
	);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			result_r <= CTRL_RST;
			daddr_r  <= CTRL_RST;
			ddata_r  <= CTRL_RST;
		end else if (res_take) begin
			result_r <= lnk.fmt_out;
			ddata_r  <= lnk.fmt_out;
			daddr_r  <= lnk.addr;
		end
	end

	// Counter restarts on enable so the first group is full length
	always_ff @(posedge clk) begin
		if (!rst_b || !on_r) begin
			ops_r  <= 4'h0;
			ptr_r  <= 7'h00;
			dreq_r <= 1'b0;
		end else begin
			dreq_r <= group_end;
			if (group_end) begin
				ops_r <= 4'h0;
				ptr_r <= (ptr_r + 7'h01) & ptr_mask;
			end else if (res_take) begin
				ops_r <= ops_r + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b || !reg_rd) begin
			rdata_r <= CTRL_RST;
		end else begin
			unique case (reg_addr)
				OFS_CTRL1: rdata_r <= {on_r, 1'b0, idle_stop_r, build_r, 1'b0, res12_r,
				                       fmt_r, trig_r, 1'b0, simul_eff, auto_r,
				                       sample_r, done_r};
				OFS_CTRL2: rdata_r <= {6'h00, chcnt_r & {2{!res12_r}}, 2'h0, incr_r, 2'h0};
				OFS_CTRL3: rdata_r <= {3'h0, smpt_r, div_r};
				OFS_CTRL4: rdata_r <= {13'h0000, blog_r};
				OFS_RESULT: rdata_r <= result_r;
				OFS_STATUS: rdata_r <= {6'h00, ch_r, ops_r, state_r};
				default: rdata_r <= CTRL_RST;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// Sequential mode keeps later channels tracking until converted
			sh_sampling[i] = active[i] && ((state_r == SCS_SAMPLE)
			               || ((state_r == SCS_CONV) && !simul_eff && (i > ch_r)));
		end
	end
	assign reg_rdata    = rdata_r;
	assign conv_start   = start_r;
	assign conv_channel = ch_r;
	assign conv_res12   = res12_r;
	assign dma_req      = dreq_r;
	assign irq_set      = dreq_r;
	assign dma_addr     = daddr_r;
	assign dma_data     = ddata_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_off_idle: assert property (!on_r |=> (state_r == SCS_OFF) && !sample_r)
		else $error("module off did not idle");
	a_done_set: assert property (seq_end |=> done_r && !conv_start)
		else $error("done not set at sequence end");
	a_done_clr: assert property (go_conv |=> !done_r && conv_start)
		else $error("done not cleared at conversion start");
	a_single_sh: assert property (res12_r |-> (sh_sampling[3:1] == 3'b000))
		else $error("extra sample/hold active in 12-bit mode");
	a_ctrl1_read: assert property (reg_rd && (reg_addr == OFS_CTRL1) |=>
		((reg_rdata & ~CTRL1_MASK) == 16'h0000)
		&& (!$past(res12_r) || !reg_rdata[B_SIMUL]))
		else $error("unimplemented control bit read as one");
	a_sw_end: assert property ((state_r == SCS_SAMPLE) && run && (trig_r == TRIG_SW)
		&& swr_end |=> (state_r == SCS_CONV) && !sample_r)
		else $error("software clear did not start conversion");
	a_auto_again: assert property (seq_end && auto_r |=> (state_r == SCS_SAMPLE)
		&& sample_r)
		else $error("auto-start did not resample");
	a_flag_rate: assert property (res_take && (ops_r == incr_r) |=> irq_set && dma_req
		&& (ops_r == 4'h0))
		else $error("flag not raised after N+1 conversions");
	a_no_early: assert property (res_take && (ops_r != incr_r) |=> !irq_set)
		else $error("flag raised early");
	a_inorder: assert property (res_take && build_r |=>
		dma_addr == {12'h000, $past(ops_r)})
		else $error("in-order address wrong");
	a_idle_halt: assert property (on_r && idle_stop_r && idle_mode |=> $stable(state_r))
		else $error("sequencer moved while halted in idle");
	a_pin_trig: assert property ((state_r == SCS_SAMPLE) && run && (trig_r == TRIG_PIN)
		&& pin_rise |=> (state_r == SCS_CONV))
		else $error("pin edge did not end sampling");
	a_int12_fmt: assert property (res_take && res12_r && (fmt_r == FMT_INT) |=>
		(result_r[15:12] == 4'h0))
		else $error("12-bit integer not right-justified");
	a_frac10_fmt: assert property (res_take && !res12_r && (fmt_r == FMT_FRAC) |=>
		(result_r[5:0] == 6'h00))
		else $error("10-bit fraction not left-justified");

	c_simul_seq: cover property (seq_end && simul_eff && (last_ch == 2'd3));
	c_flag:      cover property (irq_set && !build_r);
	c_pin_conv:  cover property (go_conv && (trig_r == TRIG_PIN));
	c_auto_loop: cover property (seq_end && auto_r && (trig_r == TRIG_AUTO));

endmodule // scs_sequencer
`default_nettype wire

// ---- logic/scs_pkg.sv ----
`default_nettype none
package scs_pkg;

	// ------------------------------------------------------------
	// Register map (word index on the register port)
	// ------------------------------------------------------------
	localparam int              REG_AW     = 3;
	localparam int              DW         = 16;
	localparam int              RAW_W      = 12;
	localparam logic [2:0]      OFS_CTRL1  = 3'h0;
	localparam logic [2:0]      OFS_CTRL2  = 3'h1;
	localparam logic [2:0]      OFS_CTRL3  = 3'h2;
	localparam logic [2:0]      OFS_CTRL4  = 3'h3;
	localparam logic [2:0]      OFS_RESULT = 3'h4;
	localparam logic [2:0]      OFS_STATUS = 3'h5;
	localparam logic [DW-1:0]   CTRL_RST   = 16'h0000;
	// Writable and readable positions of converter_control_one
	localparam logic [DW-1:0]   CTRL1_MASK = 16'hB7EF;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int B_ON     = 15;
	localparam int B_IDLE   = 13;
	localparam int B_BUILD  = 12;
	localparam int B_RES12  = 10;
	localparam int B_FMT    = 8;
	localparam int B_TRIG   = 5;
	localparam int B_SIMUL  = 3;
	localparam int B_AUTO   = 2;
	localparam int B_SAMPLE = 1;
	localparam int B_DONE   = 0;
	localparam int B_CHCNT  = 8;
	localparam int B_INCR   = 2;
	localparam int B_SMPT   = 8;
	localparam int B_DIV    = 0;
	localparam int B_BLOG   = 0;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [2:0] TRIG_SW     = 3'h0;
	localparam logic [2:0] TRIG_PIN    = 3'h1;
	localparam logic [2:0] TRIG_TMR_LO = 3'h2;
	localparam logic [2:0] TRIG_TMR_HI = 3'h4;
	localparam logic [2:0] TRIG_AUTO   = 3'h7;
	localparam logic [1:0] FMT_INT     = 2'h0;
	localparam logic [1:0] FMT_SINT    = 2'h1;
	localparam logic [1:0] FMT_FRAC    = 2'h2;
	localparam logic [1:0] FMT_SFRAC   = 2'h3;

	typedef enum logic [3:0] {
		SCS_OFF    = 4'b0001,
		SCS_WAIT   = 4'b0010,
		SCS_SAMPLE = 4'b0100,
		SCS_CONV   = 4'b1000
	} scs_state_t;

endpackage
`default_nettype wire

// ---- logic/scs_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface scs_link_if;
	import scs_pkg::*;
	logic [RAW_W-1:0] raw;
	logic             res12;
	logic [1:0]       fmt;
	logic [DW-1:0]    fmt_out;
	logic             build;
	logic [2:0]       blog;
	logic [4:0]       ain;
	logic [3:0]       op_idx;
	logic [6:0]       ptr;
	logic [DW-1:0]    addr;
	modport core      (output raw, res12, fmt, build, blog, ain, op_idx, ptr,
	                   input fmt_out, addr);
	modport formatter (input raw, res12, fmt, output fmt_out);
	modport addresser (input build, blog, ain, op_idx, ptr, output addr);
endinterface
`default_nettype wire

// ---- logic/scs_fmt.sv ----
`timescale 1ns/1ps
`default_nettype none
module scs_fmt (
	// Link to sequencer
	scs_link_if.formatter lnk
);
	import scs_pkg::*;
	logic [9:0]  d10;
	logic [11:0] d12;
	always_comb begin
		d10 = lnk.raw[9:0];
		d12 = lnk.raw[11:0];
		if (lnk.res12) begin
			unique case (lnk.fmt)
				FMT_INT:   lnk.fmt_out = {4'h0, d12};
				FMT_SINT:  lnk.fmt_out = {{5{~d12[11]}}, d12[10:0]};
				FMT_FRAC:  lnk.fmt_out = {d12, 4'h0};
				FMT_SFRAC: lnk.fmt_out = {~d12[11], d12[10:0], 4'h0};
			endcase
		end else begin
			unique case (lnk.fmt)
				FMT_INT:   lnk.fmt_out = {6'h00, d10};
				FMT_SINT:  lnk.fmt_out = {{7{~d10[9]}}, d10[8:0]};
				FMT_FRAC:  lnk.fmt_out = {d10, 6'h00};
				FMT_SFRAC: lnk.fmt_out = {~d10[9], d10[8:0], 6'h00};
			endcase
		end
	end
endmodule // scs_fmt
`default_nettype wire

// ---- logic/scs_dma_addr.sv ----
`timescale 1ns/1ps
`default_nettype none
module scs_dma_addr (
	// Link to sequencer
	scs_link_if.addresser lnk
);
	import scs_pkg::*;
	logic [DW-1:0] mask;
	logic [DW-1:0] sg;
	always_comb begin
		mask = (16'h0001 << lnk.blog) - 16'h0001;
		// Input index selects the block, pointer walks inside it
		sg = ({11'h000, lnk.ain} << lnk.blog) | ({9'h000, lnk.ptr} & mask);
		lnk.addr = lnk.build ? {12'h000, lnk.op_idx} : sg;
	end
endmodule // scs_dma_addr
`default_nettype wire

// ---- dv/scs_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scs_core_model #(
	parameter int          LAT  = 3,
	parameter logic [11:0] BASE = 12'h0A65
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Sequencer side
	input  wire logic        conv_start,
	input  wire logic [1:0]  conv_channel,
	output logic             conv_done,
	output logic      [11:0] conv_data,
	output logic      [4:0]  conv_input_idx
);
	logic       busy_r;
	logic [7:0] cnt_r;
	logic [1:0] ch_r;
	// Result lines toggle outside the done pulse so a late sample shows up
	always_ff @(posedge clk) begin
		conv_done      <= 1'b0;
		conv_data      <= ~conv_data;
		conv_input_idx <= ~conv_input_idx;
		if (!rst_b) begin
			busy_r         <= 1'b0;
			cnt_r          <= '0;
			ch_r           <= '0;
			conv_data      <= '0;
			conv_input_idx <= '0;
		end else if (conv_start) begin
			busy_r <= 1'b1;
			cnt_r  <= 8'(LAT);
			ch_r   <= conv_channel;
		end else if (busy_r && cnt_r == 0) begin
			busy_r         <= 1'b0;
			conv_done      <= 1'b1;
			conv_data      <= BASE + 12'(ch_r);
			conv_input_idx <= 5'(ch_r) + 5'h04;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule // scs_core_model
`default_nettype wire

// ---- dv/sar_converter_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_converter_sequencer_test;
	import scs_pkg::*;
	logic              clk, rst_b, reg_wr, reg_rd, idle_mode;
	logic [REG_AW-1:0] reg_addr;
	logic [DW-1:0]     reg_wdata, reg_rdata, dma_addr, dma_data, v;
	logic [2:0]        src;
	logic [3:0]        sh_sampling;
	logic [1:0]        conv_channel;
	logic              conv_start, conv_res12, conv_done, dma_req, irq_set;
	logic [RAW_W-1:0]  conv_data;
	logic [4:0]        conv_input_idx;
	int                error_cnt, n_tests, cyc, n_start, n_done, n_req;

	scs_sequencer #(.MODULE_IDX(0)) dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.idle_mode(idle_mode), .external_interrupt_pin(src[0]),
		.general_timer_b_match(src[1]), .general_timer_c_match(src[2]),
		.sh_sampling(sh_sampling), .conv_start(conv_start), .conv_channel(conv_channel),
		.conv_res12(conv_res12), .conv_done(conv_done), .conv_data(conv_data),
		.conv_input_idx(conv_input_idx), .dma_req(dma_req), .dma_addr(dma_addr),
		.dma_data(dma_data), .irq_set(irq_set));
	scs_core_model core (.clk(clk), .rst_b(rst_b), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data),
		.conv_input_idx(conv_input_idx));

	// ------------------------------------------------------------
	// Clock, reset, event counters, timeout
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc     <= cyc + 1;
		n_start <= n_start + int'(conv_start);
		n_done  <= n_done + int'(conv_done);
		n_req   <= n_req + int'(dma_req);
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [REG_AW-1:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [15:0] fexp(input logic r, input logic [1:0] f, input logic [11:0] d);
		case ({r, f})
			3'b000:  return {6'h00, d[9:0]};
			3'b001:  return {{7{~d[9]}}, d[8:0]};
			3'b010:  return {d[9:0], 6'h00};
			3'b011:  return {~d[9], d[8:0], 6'h00};
			3'b100:  return {4'h0, d};
			3'b101:  return {{5{~d[11]}}, d[10:0]};
			3'b110:  return {d, 4'h0};
			default: return {~d[11], d[10:0], 4'h0};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd(OFS_CTRL1);
		chk(v, CTRL_RST);
		wr(OFS_CTRL1, 16'h7FFE);
		rd(OFS_CTRL1);
		chk(v, 16'h37E4);
		rd(3'h6);
		chk(v, 16'h0000);
		wr(OFS_CTRL1, 16'h0000);
		$display("test regs done");
	endtask

	// Software trigger, scatter/gather address, every format in both resolutions
	task automatic t_fmt(input logic r, input logic [1:0] f);
		logic [15:0] c;
		c = 16'h8000 | (16'(r) << 10) | (16'(f) << 8);
		wr(OFS_CTRL4, 16'h0002);
		wr(OFS_CTRL2, 16'h0100);
		wr(OFS_CTRL1, c);
		idle(3);
		wr(OFS_CTRL1, c | 16'h0002);
		@(posedge clk);
		#1 chk(16'(sh_sampling), r ? 16'h0001 : 16'h0003);
		chk(16'(conv_res12), 16'(r));
		rd(OFS_CTRL1);
		chk(v, c | 16'h0002);
		wr(OFS_CTRL1, c);
		for (int ch = 0; ch < (r ? 1 : 2); ch++) begin
			// Step past the previous pulse so each result is judged once
			@(posedge clk);
			#1;
			for (int i = 0; i < 50 && dma_req !== 1'b1; i++) begin
				@(posedge clk);
				#1;
			end
			chk(16'(irq_set), 16'h0001);
			chk(dma_data, fexp(r, f, 12'h0A65 + 12'(ch)));
			chk(dma_addr, 16'(((ch + 4) << 2) | ch));
		end
		rd(OFS_CTRL1);
		chk(v, c | 16'h0001);
		wr(OFS_CTRL1, c);
		rd(OFS_CTRL1);
		chk(v, c);
		wr(OFS_CTRL1, 16'h0000);
		$display("test format %0d %0d done", r, f);
	endtask

	// Auto-start with counter trigger, flag every third result, then switch off
	task automatic t_auto();
		int d0, q0;
		wr(OFS_CTRL2, 16'h0208);
		wr(OFS_CTRL3, 16'h0000);
		d0 = n_done;
		q0 = n_req;
		wr(OFS_CTRL1, 16'h90E4);
		for (int i = 0; i < 2000 && n_done - d0 < 12; i++) @(posedge clk);
		wr(OFS_CTRL1, 16'h0000);
		idle(3);
		chk(16'(n_req - q0), 16'((n_done - d0) / 3));
		chk(16'(n_done - d0 >= 12), 16'h0001);
		rd(OFS_STATUS);
		chk(v & 16'h000F, 16'h0001);
		chk(16'(sh_sampling), 16'h0000);
		$display("test auto done");
	endtask

	// Each hardware trigger starts conversion only on its own source
	task automatic t_trig(input logic [2:0] code, input logic [2:0] good);
		int s0;
		wr(OFS_CTRL2, 16'h0000);
		wr(OFS_CTRL1, 16'h8000 | (16'(code) << 5));
		idle(3);
		wr(OFS_CTRL1, 16'h8002 | (16'(code) << 5));
		idle(2);
		s0 = n_start;
		src <= ~good;
		@(posedge clk);
		src <= 3'h0;
		idle(5);
		chk(16'(n_start - s0), 16'h0000);
		src <= good;
		@(posedge clk);
		src <= 3'h0;
		idle(5);
		chk(16'(n_start - s0), 16'(good != 3'h0));
		rd(OFS_CTRL1);
		chk(v & 16'h0002, (good != 3'h0) ? 16'h0000 : 16'h0002);
		wr(OFS_CTRL1, 16'h0000);
		idle(8);
		$display("test trigger %0d done", code);
	endtask

	// Idle-stop freezes sampling, then four channels hold together
	task automatic t_idle();
		int s0;
		wr(OFS_CTRL2, 16'h0200);
		wr(OFS_CTRL1, 16'hA008);
		idle(3);
		wr(OFS_CTRL1, 16'hA00A);
		s0 = n_start;
		idle_mode <= 1'b1;
		wr(OFS_CTRL1, 16'hA008);
		idle(3);
		chk(16'(n_start - s0), 16'h0000);
		rd(OFS_STATUS);
		chk(v & 16'h000F, 16'h0004);
		idle_mode <= 1'b0;
		wr(OFS_CTRL1, 16'hA008);
		@(posedge clk);
		#1 chk(16'(sh_sampling), 16'h0000);
		idle(30);
		chk(16'(n_start - s0), 16'h0004);
		rd(OFS_CTRL1);
		chk(v, 16'hA009);
		wr(OFS_CTRL1, 16'h0000);
		idle(3);
		$display("test idle done");
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		{rst_b, reg_wr, reg_rd, idle_mode} = 4'h0;
		{reg_addr, reg_wdata, src} = '0;
		{error_cnt, n_tests, cyc, n_start, n_done, n_req} = '0;
		idle(5);
		rst_b <= 1'b1;
		t_regs();
		for (int k = 0; k < 8; k++) t_fmt(k[2], k[1:0]);
		t_auto();
		t_trig(TRIG_PIN, 3'h1);
		t_trig(TRIG_TMR_HI, 3'h4);
		t_trig(TRIG_TMR_LO, 3'h2);
		t_trig(3'h3, 3'h0);
		t_idle();
		finish_test();
	end
endmodule // sar_converter_sequencer_test
`default_nettype wire
